// *** hdl/serial_peer_defines.vh ***
// constants and register map of the serial peer controller
`ifndef SERIAL_PEER_DEFINES_VH
`define SERIAL_PEER_DEFINES_VH

// ----------------------------------------------------------------
// device registers, reached only through the device's own core
// ----------------------------------------------------------------
`define DEV_IRQ_DISABLE_OFS 8'hDC
`define DEV_SHIFT_DATA_OFS 8'hDD

// ----------------------------------------------------------------
// controller registers
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_TXDATA 8'h04
`define REG_RXDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_DIV 8'h10

`define CTRL_CLK_MASTER 0
`define CTRL_ACK_EN 1
`define CTRL_STRETCH 2
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_CONFLICT 2
`define STAT_ACK 3
`define CTRL_RESET 8'h01

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_SYS_MHZ 25
`define SCL_HALF_NS 160
// half period of 160 ns at 25 MHz, rounded up, sized for the divider register
`define SCL_HALF_CYC 8'h04
`define BITS_PER_BYTE 4'h8

`endif

// *** hdl/pin_sync.v ***
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter WIDTH = 3
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
			reg meta_r;
			reg sync_r;
			// first stage feeds only the second
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
				end else begin
					meta_r <= d[i];
					sync_r <= meta_r;
				end
			end
			assign q[i] = sync_r;
		end
	endgenerate
endmodule // pin_sync

// *** hdl/clk_divider.v ***
// half-period tick generator for the shift clock
`timescale 1ns/10ps
module clk_divider #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire rst_n,
	input wire restart,
	input wire [WIDTH-1:0] half,
	output reg tick
);
	reg [WIDTH-1:0] cnt_r;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else if (restart) begin
			cnt_r <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else if (cnt_r + 1'b1 >= half) begin
			// a half of zero still gives a tick every cycle
			cnt_r <= {WIDTH{1'b0}};
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // clk_divider

// *** hdl/serial_peer.v ***
// serial peer that exchanges bytes with the device's shift port
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`include "serial_peer_defines.vh"
module serial_peer (
	input wire clk_sys,
	input wire rstn,
	input wire [7:0] addr,
	input wire [7:0] wr_data,
	input wire wr_stb,
	input wire rd_stb,
	output reg [7:0] rd_data,
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe_n,
	input wire sin_i,
	output reg sin_o,
	output reg sin_oe_n,
	input wire sout_i,
	output reg ce_n
);
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam ST_IDLE = 3'd0;
	localparam ST_LOW = 3'd1;
	localparam ST_RISE = 3'd2;
	localparam ST_HIGH = 3'd3;
	localparam ST_HOLD = 3'd4;
	localparam ST_STOP = 3'd5;
	localparam ST_SLV = 3'd6;

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	reg rst_meta_r;
	reg rst_n_r;
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	wire [2:0] pins_s;
	pin_sync #(.WIDTH(3)) u_sync (
		.clk(clk_sys),
		.rst_n(rst_n_r),
		.d({sout_i, sin_i, scl_i}),
		.q(pins_s)
	);
	wire scl_s = pins_s[0];
	wire sin_s = pins_s[1];
	wire sout_s = pins_s[2];

	reg scl_d_r;
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [7:0] ctrl_r;
	reg [7:0] div_r;
	reg [7:0] tx_sh_r;
	reg [7:0] rx_sh_r;
	reg [7:0] rx_data_r;
	reg done_r;
	reg conflict_r;
	reg ack_r;
	reg [2:0] state_r;
	reg [3:0] bit_cnt_r;
	reg div_restart_r;
	wire tick;

	wire busy = (state_r != ST_IDLE);
	wire wr_ctrl = wr_stb && (addr == `REG_CTRL);
	wire wr_tx = wr_stb && (addr == `REG_TXDATA);
	wire wr_stat = wr_stb && (addr == `REG_STATUS);
	wire wr_div = wr_stb && (addr == `REG_DIV);
	wire clk_master = ctrl_r[`CTRL_CLK_MASTER];
	wire ack_en = ctrl_r[`CTRL_ACK_EN];
	wire stretch = ctrl_r[`CTRL_STRETCH];
	wire ack_slot = (bit_cnt_r == `BITS_PER_BYTE);

	clk_divider #(.WIDTH(8)) u_div (
		.clk(clk_sys),
		.rst_n(rst_n_r),
		.restart(div_restart_r),
		.half(div_r),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// host port
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r <= `CTRL_RESET;
			div_r <= `SCL_HALF_CYC;
		end else begin
			if (wr_ctrl && !busy) begin
				ctrl_r <= {5'h00, wr_data[2:0]};
			end
			if (wr_div && !busy) begin
				div_r <= wr_data;
			end
		end
	end

	always @(posedge clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rd_data <= 8'h00;
		end else if (rd_stb) begin
			case (addr)
				`REG_CTRL: rd_data <= ctrl_r;
				`REG_TXDATA: rd_data <= tx_sh_r;
				`REG_RXDATA: rd_data <= rx_data_r;
				`REG_STATUS: rd_data <= {4'h0, ack_r, conflict_r, done_r, busy};
				`REG_DIV: rd_data <= div_r;
				default: rd_data <= 8'h00;
			endcase
		end else begin
			rd_data <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// transfer engine
	// ----------------------------------------------------------------
	// the device changes its output on falling edges, so when we make the clock its data is
	// sampled late in the high phase and ours changes in mid-low; in ST_SLV we sample on rises and change on falls
	always @(posedge clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			tx_sh_r <= 8'h00;
			rx_sh_r <= 8'h00;
			rx_data_r <= 8'h00;
			done_r <= 1'b0;
			conflict_r <= 1'b0;
			ack_r <= 1'b0;
			scl_d_r <= 1'b1;
			scl_o <= 1'b0;
			scl_oe_n <= 1'b1;
			sin_o <= 1'b0;
			sin_oe_n <= 1'b1;
			ce_n <= 1'b1;
			div_restart_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			div_restart_r <= 1'b0;
			// a clear write loses against a completion in the same cycle
			if (wr_stat && wr_data[`STAT_DONE]) begin
				done_r <= 1'b0;
			end
			if (wr_stat && wr_data[`STAT_CONFLICT]) begin
				conflict_r <= 1'b0;
			end
			case (state_r)
				ST_IDLE: begin
					scl_oe_n <= ~(stretch & done_r & ~clk_master);
					sin_oe_n <= 1'b1;
					if (wr_tx) begin
						// chip enable frames the byte for the device
						ce_n <= 1'b0;
						tx_sh_r <= {wr_data[6:0], 1'b0};
						sin_oe_n <= wr_data[7];
						bit_cnt_r <= 4'h0;
						ack_r <= 1'b0;
						div_restart_r <= 1'b1;
						// the clock idles high: the first fall must be the first shift
						state_r <= clk_master ? ST_HIGH : ST_SLV;
					end
				end
				ST_LOW: begin
					// we supply the clock: drive it low
					scl_oe_n <= 1'b0;
					if (tick) begin
						scl_oe_n <= 1'b1;
						state_r <= ST_RISE;
					end
				end
				ST_RISE: begin
					// the device may hold the clock low to unload its data
					if (scl_s) begin
						div_restart_r <= 1'b1;
						state_r <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (tick) begin
						if (ack_slot) begin
							ack_r <= ~sin_s;
						end else begin
							rx_sh_r <= {rx_sh_r[6:0], sout_s};
							if (sin_oe_n && !sin_s) begin
								conflict_r <= 1'b1;
							end
						end
						// falling edge: the device shifts and counts here
						scl_oe_n <= 1'b0;
						bit_cnt_r <= bit_cnt_r + 4'h1;
						state_r <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (tick) begin
						if ((bit_cnt_r == `BITS_PER_BYTE + 4'h1) || (bit_cnt_r == `BITS_PER_BYTE && !ack_en)) begin
							state_r <= ST_STOP;
						end else if (bit_cnt_r == `BITS_PER_BYTE) begin
							// released so the device can pull the ack low
							sin_oe_n <= 1'b1;
							rx_data_r <= rx_sh_r;
							state_r <= ST_LOW;
						end else begin
							sin_oe_n <= tx_sh_r[7];
							tx_sh_r <= {tx_sh_r[6:0], 1'b0};
							state_r <= ST_LOW;
						end
					end
				end
				ST_STOP: begin
					// eight falls stop the device's counter; no more pulses
					if (!ack_en) begin
						rx_data_r <= rx_sh_r;
					end
					scl_oe_n <= 1'b1;
					sin_oe_n <= 1'b1;
					ce_n <= 1'b1;
					done_r <= 1'b1;
					state_r <= ST_IDLE;
				end
				ST_SLV: begin
					// device software makes the clock; we follow its edges
					if (scl_rise) begin
						rx_sh_r <= {rx_sh_r[6:0], sout_s};
					end
					if (scl_fall) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
						sin_oe_n <= tx_sh_r[7];
						tx_sh_r <= {tx_sh_r[6:0], 1'b0};
						if (bit_cnt_r == 4'h7) begin
							rx_data_r <= rx_sh_r;
							sin_oe_n <= 1'b1;
							ce_n <= 1'b1;
							done_r <= 1'b1;
							state_r <= ST_IDLE;
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // serial_peer

// *** verif/serial_peer_chk.sv ***
// pin-level assertions for the serial peer controller
`timescale 1ns/10ps
`include "serial_peer_defines.vh"
module serial_peer_chk (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] rd_data,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_n,
	input wire logic sin_i,
	input wire logic sin_o,
	input wire logic sin_oe_n,
	input wire logic sout_i,
	input wire logic ce_n
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence tx_start;
		wr_stb && addr == `REG_TXDATA && ce_n ##1 !ce_n;
	endsequence
	sequence clk_pull;
		$fell(scl_oe_n);
	endsequence
	a_read_idle: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
		else $error("read data outside its cycle");
	a_msb_first: assert property (tx_start |-> sin_oe_n == $past(wr_data[7]))
		else $error("first bit is not the msb");
	a_low_phase: assert property (clk_pull |-> !scl_oe_n [*3])
		else $error("clock low phase too short");
	a_drive_zero: assert property (!scl_o && !sin_o)
		else $error("open drain output drives high");
	// a data change while the clock is high would look like a start or stop
	a_bit_steady: assert property (!ce_n && !$past(ce_n) && scl_i && $past(scl_i) |-> $stable(sin_oe_n))
		else $error("data changed while clock high");
	a_end_release: assert property ($rose(ce_n) |-> scl_oe_n && sin_oe_n)
		else $error("lines not released at frame end");
	a_frame_start: assert property ($fell(ce_n) |-> scl_oe_n)
		else $error("clock pulled before select");
	a_idle_free: assert property (ce_n |-> sin_oe_n)
		else $error("data pulled while idle");
endmodule // serial_peer_chk

bind serial_peer serial_peer_chk i_serial_peer_chk (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
	.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe_n(scl_oe_n), .sin_i(sin_i), .sin_o(sin_o), .sin_oe_n(sin_oe_n), .sout_i(sout_i), .ce_n(ce_n));

// *** verif/shift_port_model.sv ***
// behavioural model of the device's serial shift port
`timescale 1ns/10ps
module shift_port_model (
	input wire scl,
	input wire sin,
	output wire sout,
	output reg irq_n
);
	reg [7:0] shift_r;
	reg [3:0] cnt_r;
	reg armed_r;
	wire counter_terminal_output = ~cnt_r[3];
	initial begin
		shift_r = 8'h00;
		cnt_r = 4'h0;
		armed_r = 1'b0;
		irq_n = 1'b1;
	end
	assign sout = shift_r[7];
	always @(negedge scl) begin
		if (counter_terminal_output) begin
			shift_r <= {shift_r[6:0], sin};
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == 4'h7 && armed_r) irq_n <= 1'b0;
		end
	end
	task load(input [7:0] d);
		begin
			shift_r <= d;
			cnt_r <= 4'h0;
			armed_r <= 1'b1;
			irq_n <= 1'b1;
		end
	endtask
	// written value is ignored on purpose
	task disarm;
		begin
			armed_r <= 1'b0;
			irq_n <= 1'b1;
		end
	endtask
endmodule // shift_port_model

// *** verif/tb_serial_peer.sv ***
// testbench for the serial peer controller
`timescale 1ns/10ps
`include "serial_peer_defines.vh"
module tb_serial_peer;
	reg clk_sys, rstn, wr_stb, rd_stb;
	reg [7:0] addr, wr_data, s;
	wire [7:0] rd_data;
	wire scl_o, scl_oe_n, sin_o, sin_oe_n, ce_n, sout, irq_n;
	// both wires are open drain with pull-ups
	wire scl = scl_oe_n;
	wire sin = sin_oe_n;
	integer error_cnt, checked, n;
	serial_peer i_serial_peer (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .scl_i(scl), .scl_o(scl_o),
		.scl_oe_n(scl_oe_n), .sin_i(sin), .sin_o(sin_o), .sin_oe_n(sin_oe_n), .sout_i(sout), .ce_n(ce_n));
	shift_port_model i_shift_port_model (.scl(scl), .sin(sin), .sout(sout), .irq_n(irq_n));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task results;
		begin
			$display("comparisons %0d mismatches %0d", checked, error_cnt);
			if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	task chk(input [8*10-1:0] what, input [7:0] seen, input [7:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("MISMATCH %0s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys);
			addr <= a;
			wr_data <= d;
			wr_stb <= 1'b1;
			@(posedge clk_sys);
			wr_stb <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge clk_sys);
			addr <= a;
			rd_stb <= 1'b1;
			@(posedge clk_sys);
			rd_stb <= 1'b0;
			@(negedge clk_sys);
			s = rd_data;
		end
	endtask
	// polling bound is far above one byte at the reset divider
	task wait_done;
		begin
			n = 0;
			s = 8'h00;
			while (s[1] !== 1'b1 && n < 300) begin
				rd(`REG_STATUS);
				n = n + 1;
			end
			if (s[1] !== 1'b1) begin
				error_cnt = error_cnt + 1;
				results;
			end
		end
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
		error_cnt = 0;
		checked = 0;
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(`REG_CTRL); chk("ctrl", s, `CTRL_RESET);
		rd(`REG_DIV); chk("div", s, `SCL_HALF_CYC);
		rd(8'h20); chk("unmapped", s, 8'h00);
		chk("irq_reset", {7'h00, irq_n}, 8'h01);
		$display("test reset done");
		i_shift_port_model.load(8'hA5);
		wr(`REG_TXDATA, 8'h3C);
		wr(`REG_TXDATA, 8'hFF);
		wait_done;
		rd(`REG_RXDATA); chk("rx", s, 8'hA5);
		chk("dev_shift", i_shift_port_model.shift_r, 8'h3C);
		chk("irq", {7'h00, irq_n}, 8'h00);
		rd(`REG_STATUS); chk("status", s, 8'h02);
		$display("test exchange done");
		wr(`REG_STATUS, 8'h02);
		i_shift_port_model.disarm;
		wr(`REG_TXDATA, 8'h81);
		wait_done;
		rd(`REG_RXDATA); chk("rx_stuck", s, 8'h00);
		chk("dev_hold", i_shift_port_model.shift_r, 8'h3C);
		chk("irq_off", {7'h00, irq_n}, 8'h01);
		$display("test stopped counter done");
		results;
	end
endmodule // tb_serial_peer
